// file: src/load_switch_fault_sequencer.sv
// Operation
// - enabled: enable low and no undervoltage lockout
// - lockout blocks switch below input threshold
// - level select picks 33 V or 23 V trip
// - capture level select at enable, hold it
// - over-voltage while on: off after debounce
// - over-voltage while off keeps switch off
// - any over-voltage pulls fault flag low
// - small input-output drop forces switch off
// - die overheat turns switch off
// - auto-restart: restart only below hysteresis level
// - auto-restart: thermal recovery uses full soft-start
// - latch-off: thermal latches until enable toggles
// - enable starts linear ramp, external duration
// - check faults, then delay, then switch on
// - inrush clamped 500 us shuts switch down
// - inrush timer restarts when clamp releases
// - limit and short shutdown disabled once on
// - auto-restart: retry every 64 ms forever
// - latch-off: four retries 2 ms apart, latch
// - over-voltage debounce is 512 us
// - reverse clear: switch back on, flag released
`timescale 1ns/1ps
module load_switch_fault_sequencer
  import lsw_pkg::*;
#(
  parameter bit AUTO_RESTART    = 1'b1,
  parameter int OVP_DEB_CYCLES  = OVP_DEB_CYC,
  parameter int INRUSH_CYCLES   = INRUSH_CYC,
  parameter int RETRY_A_CYCLES  = RETRY_AUTO_CYC,
  parameter int RETRY_L_CYCLES  = RETRY_LATCH_CYC,
  parameter int EN_DELAY_CYCLES = EN_DELAY_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // host side
  input  wire logic switch_enable_low,
  output logic      fault_flag_low_o,
  output logic      fault_flag_low_oe,
  // analogue comparator levels
  input  wire logic input_undervoltage_lockout,
  input  wire logic ovp_level_select,
  input  wire logic ovp_over_33v,
  input  wire logic ovp_over_23v,
  input  wire logic reverse_block_condition,
  input  wire logic thermal_hot,
  input  wire logic thermal_cool,
  input  wire logic inrush_at_limit,
  input  wire logic ramp_done,
  // switch control
  output logic      switch_on,
  output logic      soft_start_run,
  output logic      low_threshold_sel
);
  sync_if sif ();
  seq_state_t   st_r, st_nxt;
  logic [CNT_W-1:0] tmr_r;
  logic [CNT_W-1:0] ovp_cnt_r;
  logic [2:0]   retry_r;
  logic         sel_r;
  logic         tsd_r;
  logic         en_prev_r;
  logic         en, uv, hot, cool, rev, ilim, rdone, ovp_lvl, ovp_trip;
  logic         enabled, fault;

  // --------------------------------------------------------------------
  // synchronise pin levels
  // --------------------------------------------------------------------
  assign sif.raw = {~switch_enable_low, input_undervoltage_lockout,
                    thermal_hot, thermal_cool, reverse_block_condition,
                    inrush_at_limit, ramp_done};
  level_sync #(.W(7)) u_sync (
    .clk (clk),
    .rst (rst),
    .s   (sif.src)
  );
  assign {en, uv, hot, cool, rev, ilim, rdone} = sif.lvl;

  // over-voltage comparators share one sampler path
  logic [2:0] ov_s1_r, ov_s2_r, ov_s3_r;
  logic [2:0] ov_lvl_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ov_s1_r  <= '0;
      ov_s2_r  <= '0;
      ov_s3_r  <= '0;
      ov_lvl_r <= '0;
    end else begin
      ov_s1_r  <= {ovp_over_33v, ovp_over_23v, ovp_level_select};
      ov_s2_r  <= ov_s1_r;
      ov_s3_r  <= ov_s2_r;
      ov_lvl_r <= (ov_lvl_r & ~(ov_s2_r ^ ov_s3_r))
                | (ov_s3_r & ~(ov_s2_r ^ ov_s3_r));
    end
  end

  // --------------------------------------------------------------------
  // enable qualification and threshold capture
  // --------------------------------------------------------------------
  assign enabled = en && !uv;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= enabled;
    end
  end

  // latched only at the enable edge, later swings are ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_r <= 1'b0;
    end else if (enabled && !en_prev_r) begin
      sel_r <= ov_lvl_r[0];
    end
  end

  assign ovp_lvl = sel_r ? ov_lvl_r[1] : ov_lvl_r[2];

  // --------------------------------------------------------------------
  // over-voltage debounce, counts only while switch is on
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovp_cnt_r <= '0;
    end else if (!ovp_lvl || !switch_on) begin
      ovp_cnt_r <= '0;
    end else if (ovp_cnt_r != CNT_W'(OVP_DEB_CYCLES)) begin
      ovp_cnt_r <= ovp_cnt_r + 1'b1;
    end
  end
  // when off, the level itself blocks; when on, after the debounce
  assign ovp_trip = ovp_lvl &&
    (!switch_on || ovp_cnt_r == CNT_W'(OVP_DEB_CYCLES));

  // --------------------------------------------------------------------
  // thermal latch with hysteresis
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tsd_r <= 1'b0;
    end else if (hot) begin
      tsd_r <= 1'b1;
    end else if (AUTO_RESTART && cool) begin
      tsd_r <= 1'b0;
    end else if (!AUTO_RESTART && !enabled) begin
      tsd_r <= 1'b0;
    end
  end

  assign fault = ovp_trip || tsd_r;

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_OFF:   if (enabled) st_nxt = ST_CHECK;
      ST_CHECK: if (!fault && !rev) st_nxt = ST_DELAY;
      ST_DELAY: if (tmr_r == CNT_W'(EN_DELAY_CYCLES)) st_nxt = ST_RAMP;
      ST_RAMP: begin
        if (tmr_r == CNT_W'(INRUSH_CYCLES)) begin
          if (!AUTO_RESTART && retry_r == 3'(RETRY_LATCH_CNT))
            st_nxt = ST_LATCH;
          else
            st_nxt = ST_RETRY;
        end else if (rdone) begin
          st_nxt = ST_ON;
        end
      end
      ST_ON:    ;
      ST_RETRY: if (tmr_r == CNT_W'(AUTO_RESTART ? RETRY_A_CYCLES
                                                 : RETRY_L_CYCLES))
                  st_nxt = ST_CHECK;
      ST_LATCH: ;
      default:  st_nxt = ST_OFF;
    endcase
    // auto-restart: thermal and over-voltage restart through a full soft-start; latch-off goes to ST_LATCH
    if (st_r inside {ST_DELAY, ST_RAMP, ST_ON} && fault)
      st_nxt = (!AUTO_RESTART) ? ST_LATCH : ST_CHECK;
    if (!enabled) st_nxt = ST_OFF;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // shared interval timer; inrush phase resets while below the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_r <= '0;
    end else if (st_nxt != st_r) begin
      tmr_r <= '0;
    end else if (st_r == ST_RAMP && !ilim) begin
      tmr_r <= '0;
    end else if (st_r inside {ST_DELAY, ST_RAMP, ST_RETRY}) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // retry count; cleared by disable or by a successful start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      retry_r <= '0;
    end else if (!enabled || st_r == ST_ON) begin
      retry_r <= '0;
    end else if (st_r == ST_RAMP && st_nxt == ST_RETRY &&
                 retry_r != 3'(RETRY_LATCH_CNT)) begin
      retry_r <= retry_r + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // outputs, all registered
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_on         <= 1'b0;
      soft_start_run    <= 1'b0;
      low_threshold_sel <= 1'b0;
      fault_flag_low_o  <= 1'b0;
      fault_flag_low_oe <= 1'b1;
    end else begin
      // reverse block gates the gate drive only, no soft-start redo
      switch_on <= (st_nxt inside {ST_RAMP, ST_ON}) && !rev;
      // limit and short timer live only in ramp, gone once on
      soft_start_run    <= (st_nxt == ST_RAMP);
      low_threshold_sel <= sel_r;
      fault_flag_low_o  <= 1'b0;
      // flag driven for thermal, over-voltage, retry or latch-off, not reverse
      fault_flag_low_oe <= !(ovp_lvl || tsd_r ||
                             st_nxt inside {ST_RETRY, ST_LATCH});
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_off_when_disabled: assert property (!enabled |=> !switch_on)
    else $error("switch on while disabled");
  a_uv_blocks: assert property (uv |=> !switch_on)
    else $error("switch on in lockout");
  a_sel_hold: assert property (enabled && en_prev_r |=> $stable(sel_r))
    else $error("threshold changed mid cycle");
  a_ovp_flag: assert property (ovp_lvl |=> !fault_flag_low_oe)
    else $error("fault flag not driven on over-voltage");
  a_rev_off: assert property (rev |=> !switch_on)
    else $error("switch on during reverse block");
  a_hot_off: assert property (hot |=> ##1 !switch_on)
    else $error("switch on while hot");
  a_ovp_off_block: assert property (ovp_lvl && !switch_on |=> !switch_on)
    else $error("switch turned on under over-voltage");
  sequence s_clamp; st_r == ST_RAMP && ilim; endsequence
  a_inrush_reset: assert property (st_r == ST_RAMP && !ilim
                                   && st_nxt == ST_RAMP |=> tmr_r == 0)
    else $error("inrush timer kept counting");
  a_inrush_trip: assert property (s_clamp and
      (tmr_r == CNT_W'(INRUSH_CYCLES)) |=> st_r != ST_RAMP)
    else $error("no shutdown at inrush limit");
  a_on_no_limit: assert property (st_r == ST_ON |-> !soft_start_run)
    else $error("current limit active when on");
  a_retry_cap: assert property (retry_r <= 3'(RETRY_LATCH_CNT))
    else $error("retry count beyond limit");
endmodule : load_switch_fault_sequencer

// file: include/lsw_pkg.sv
package lsw_pkg;
  // ---------------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------------
  localparam int CLK_HZ          = 20000000;
  localparam int OVP_DEB_US      = 512;   // over-voltage debounce
  localparam int INRUSH_US       = 500;   // inrush clamp limit
  localparam int RETRY_AUTO_MS   = 64;    // auto-restart interval
  localparam int RETRY_LATCH_MS  = 2;     // latch-off variant retry delay
  localparam int RETRY_LATCH_CNT = 4;     // retries before latch-off
  localparam int EN_DELAY_US     = 9000;  // enable delay before ramp
  localparam int US_CYC          = CLK_HZ / 1000000;
  localparam int OVP_DEB_CYC     = OVP_DEB_US * US_CYC;
  localparam int INRUSH_CYC      = INRUSH_US * US_CYC;
  localparam int RETRY_AUTO_CYC  = RETRY_AUTO_MS * 1000 * US_CYC;
  localparam int RETRY_LATCH_CYC = RETRY_LATCH_MS * 1000 * US_CYC;
  localparam int EN_DELAY_CYC    = EN_DELAY_US * US_CYC;
  localparam int CNT_W           = 24;
  // ---------------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_CHECK  = 3'b001,
    ST_DELAY  = 3'b010,
    ST_RAMP   = 3'b011,
    ST_ON     = 3'b100,
    ST_RETRY  = 3'b101,
    ST_LATCH  = 3'b110
  } seq_state_t;
endpackage : lsw_pkg

// file: include/sync_if.sv
`timescale 1ns/1ps
// synchronised comparator levels handed to the sequencer
interface sync_if;
  logic [6:0] raw;
  logic [6:0] lvl;
  modport src (input raw, output lvl);
  modport dst (output raw, input lvl);
endinterface : sync_if

// file: src/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // levels
  sync_if.src       s
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;

  // --------------------------------------------------------------------
  // three stages; a change counts once stage two and three agree
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= s.raw[W-1:0];
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // only agreed bits move, so a single-cycle glitch never reaches lvl
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= (lvl_r & ~(s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
    end
  end

  assign s.lvl = lvl_r;
endmodule : level_sync

// file: verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench request, 1 = switch wanted on
  input  wire logic en_cmd,
  // open-drain fault pin of the device
  input  wire logic fault_flag_low_o,
  input  wire logic fault_flag_low_oe,
  // host pins
  output logic      switch_enable_low,
  output logic      fault_line
);
  // ---------------------------------------------------------------------
  // enable pin, driven low to request the switch
  // ---------------------------------------------------------------------
  // a latched-off device only comes back when this pin toggles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) switch_enable_low <= 1'b1;
    else switch_enable_low <= !en_cmd;
  end
  // pull-up on the flag: released reads high, never a stale level
  assign fault_line = fault_flag_low_oe ? 1'b1 : fault_flag_low_o;
endmodule : host_model

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       en_cmd = 1'b0;
  logic       lockout = 1'b0;
  logic       sel = 1'b0;
  logic       ov33 = 1'b0;
  logic       ov23 = 1'b0;
  logic       rev = 1'b0;
  logic       hot = 1'b0;
  logic       cool = 1'b1;
  logic       inrush = 1'b0;
  logic       rdone = 1'b0;
  logic       en_low, f_o, f_oe, f_line, sw_on, ss_run, thr_sel, last, s;
  logic [1:0] exp_q[$];
  int         n_fail = 0;
  int         checks = 0;

  always #25 clk = ~clk;

  host_model host_u (.clk(clk), .rst(rst), .en_cmd(en_cmd),
    .fault_flag_low_o(f_o), .fault_flag_low_oe(f_oe),
    .switch_enable_low(en_low), .fault_line(f_line));

  // short counts keep the retry and debounce runs brief
  load_switch_fault_sequencer #(.OVP_DEB_CYCLES(8),
    .INRUSH_CYCLES(10), .RETRY_A_CYCLES(40), .RETRY_L_CYCLES(20),
    .EN_DELAY_CYCLES(5)) dut_u (.clk(clk), .rst(rst),
    .switch_enable_low(en_low), .fault_flag_low_o(f_o),
    .fault_flag_low_oe(f_oe), .input_undervoltage_lockout(lockout),
    .ovp_level_select(sel), .ovp_over_33v(ov33), .ovp_over_23v(ov23),
    .reverse_block_condition(rev), .thermal_hot(hot),
    .thermal_cool(cool), .inrush_at_limit(inrush), .ramp_done(rdone),
    .switch_on(sw_on), .soft_start_run(ss_run),
    .low_threshold_sel(thr_sel));

  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // bounded wait, since synchroniser latency is only approximate
  task automatic wait_sw(input logic v, input int n);
    int i;
    i = 0;
    while (sw_on !== v && i < n) begin
      @(negedge clk);
      i++;
    end
    check("switch_on", {1'b0, sw_on}, {1'b0, v});
  endtask : wait_sw

  // each gate edge takes the oldest note, threshold select alongside
  always @(negedge clk) begin
    if (rst) last = 1'b0;
    else if (sw_on !== last) begin
      if (exp_q.size() == 0) check("switch edge", {sw_on, thr_sel}, 2'bXX);
      else check("switch edge", {sw_on, thr_sel}, exp_q.pop_front());
      last = sw_on;
    end
  end

  // watchdog well beyond the expected run of under 1000 cycles
  initial begin
    cyc(5000);
    n_fail++;
    end_of_test();
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(19164));
    cyc(16);
    check("fault line", {sw_on, f_line}, 2'b01);
    @(posedge clk);
    rst <= 1'b0;
    lockout <= 1'b1;
    sel <= 1'b1;
    en_cmd <= 1'b1;
    cyc(30);
    check("switch_on", {1'b0, sw_on}, 2'b00);
    exp_q.push_back(2'b11);
    @(posedge clk);
    lockout <= 1'b0;
    cyc(6);
    check("switch_on", {1'b0, sw_on}, 2'b00);
    wait_sw(1'b1, 30);
    check("soft start", {1'b0, ss_run}, 2'b01);
    // select moves after capture, inrush while fully on
    @(posedge clk);
    sel <= 1'b0;
    rdone <= 1'b1;
    inrush <= 1'b1;
    cyc(30);
    check("switch_on", {sw_on, thr_sel}, 2'b11);
    // 23 V trip chosen, so only that comparator rises
    exp_q.push_back(2'b01);
    exp_q.push_back(2'b11);
    @(posedge clk);
    inrush <= 1'b0;
    rdone <= 1'b0;
    ov23 <= 1'b1;
    cyc(8);
    check("switch_on", {1'b0, sw_on}, 2'b01);
    wait_sw(1'b0, 20);
    cyc(30);
    check("fault line", {sw_on, f_line}, 2'b00);
    @(posedge clk);
    ov23 <= 1'b0;
    wait_sw(1'b1, 40);
    check("soft start", {ss_run, f_line}, 2'b11);
    // reverse block: off and back, flag never pulled
    exp_q.push_back(2'b01);
    exp_q.push_back(2'b11);
    @(posedge clk);
    rev <= 1'b1;
    wait_sw(1'b0, 10);
    cyc(3);
    check("fault line", {1'b0, f_line}, 2'b01);
    @(posedge clk);
    rev <= 1'b0;
    wait_sw(1'b1, 10);
    // overheat, then only the cool comparator allows restart
    exp_q.push_back(2'b01);
    exp_q.push_back(2'b11);
    @(posedge clk);
    hot <= 1'b1;
    cool <= 1'b0;
    wait_sw(1'b0, 10);
    @(posedge clk);
    hot <= 1'b0;
    cyc(20);
    check("fault line", {sw_on, f_line}, 2'b00);
    @(posedge clk);
    cool <= 1'b1;
    wait_sw(1'b1, 30);
    check("soft start", {1'b0, ss_run}, 2'b01);
    // disable, then re-enable with a random level select
    s = 1'($urandom);
    exp_q.push_back(2'b01);
    exp_q.push_back({1'b1, s});
    exp_q.push_back({1'b0, s});
    exp_q.push_back({1'b1, s});
    exp_q.push_back({1'b0, s});
    @(posedge clk);
    en_cmd <= 1'b0;
    wait_sw(1'b0, 10);
    @(posedge clk);
    sel <= s;
    en_cmd <= 1'b1;
    wait_sw(1'b1, 30);
    // clamp bursts shorter than the timer never trip it
    repeat (3) begin
      @(posedge clk);
      inrush <= 1'b1;
      repeat ($urandom_range(9, 5)) @(posedge clk);
      inrush <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check("switch_on", {1'b0, sw_on}, 2'b01);
    @(posedge clk);
    inrush <= 1'b1;
    cyc(9);
    check("switch_on", {1'b0, sw_on}, 2'b01);
    wait_sw(1'b0, 12);
    cyc(2);
    check("fault line", {1'b0, f_line}, 2'b00);
    @(posedge clk);
    inrush <= 1'b0;
    cyc(30);
    check("switch_on", {1'b0, sw_on}, 2'b00);
    wait_sw(1'b1, 30);
    @(posedge clk);
    en_cmd <= 1'b0;
    wait_sw(1'b0, 10);
    cyc(5);
    // 33 V trip chosen: the 23 V comparator alone never trips
    exp_q.push_back(2'b10);
    exp_q.push_back(2'b00);
    @(posedge clk);
    sel <= 1'b0;
    en_cmd <= 1'b1;
    wait_sw(1'b1, 30);
    @(posedge clk);
    ov23 <= 1'b1;
    cyc(30);
    check("switch_on", {sw_on, thr_sel}, 2'b10);
    @(posedge clk);
    ov33 <= 1'b1;
    wait_sw(1'b0, 30);
    check("fault line", {1'b0, f_line}, 2'b00);
    @(posedge clk);
    ov23 <= 1'b0;
    ov33 <= 1'b0;
    en_cmd <= 1'b0;
    cyc(10);
    check("notes left", {1'b0, exp_q.size() == 0}, 2'b01);
    end_of_test();
  end
endmodule : testbench
